// [design/cgb_pkg.sv]
/*
 * Constants for the unit clock gate bank: register offsets, gate bit
 * positions, writable masks, reset values and the power mode encoding.
 * Assumes a 32-bit AHB-Lite register bus and a 7-unit gated peripheral set.
 */
package cgb_pkg;

   // ---------------------------------------------------------------
   // Register offsets (byte addresses, low 12 bits)
   // ---------------------------------------------------------------
   localparam int ADDR_W = 12;
   localparam logic [ADDR_W-1:0] CGB_RUN_OFS = 12'h104;
   localparam logic [ADDR_W-1:0] CGB_SLEEP_OFS = 12'h114;
   localparam logic [ADDR_W-1:0] CGB_CTRL_OFS = 12'h200;
   localparam logic [ADDR_W-1:0] CGB_STAT_OFS = 12'h204;
   localparam logic [ADDR_W-1:0] CGB_MASK_OFS = 12'h208;

   // ---------------------------------------------------------------
   // Gate layout
   // ---------------------------------------------------------------
   localparam int CGB_UNITS = 7;
   localparam int CGB_BIT_ASYNC_SERIAL_ZERO_GATE = 0;
   localparam int CGB_BIT_SYNC_SERIAL_ZERO_GATE = 4;
   localparam int CGB_BIT_TMR0 = 16;
   localparam int CGB_BIT_TMR1 = 17;
   localparam int CGB_BIT_TMR2 = 18;
   localparam int CGB_BIT_CMP0 = 24;
   localparam int CGB_BIT_CMP1 = 25;
   // Unit index i uses gate bit CGB_UNIT_BIT[i]
   localparam int CGB_UNIT_BIT [CGB_UNITS] = '{
      CGB_BIT_ASYNC_SERIAL_ZERO_GATE, CGB_BIT_SYNC_SERIAL_ZERO_GATE, CGB_BIT_TMR0, CGB_BIT_TMR1,
      CGB_BIT_TMR2, CGB_BIT_CMP0, CGB_BIT_CMP1};
   localparam logic [31:0] CGB_GATE_MASK = 32'h0307_0011;
   localparam logic [31:0] CGB_GATE_RESET = 32'h0000_0000;

   // ---------------------------------------------------------------
   // Control register fields
   // ---------------------------------------------------------------
   localparam int CGB_CTRL_ACG_BIT = 0;
   localparam logic CGB_ACG_RESET = 1'b0;

   // ---------------------------------------------------------------
   // Bus encodings
   // ---------------------------------------------------------------
   localparam int CGB_HTRANS_ACTIVE_BIT = 1;
   localparam logic CGB_HRESP_OKAY = 1'b0;
   localparam logic [31:0] CGB_RDATA_NONE = 32'h0000_0000;

   // ---------------------------------------------------------------
   // Processor power mode
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      CGB_MODE_RUN = 2'b00,
      CGB_MODE_SLEEP = 2'b01,
      CGB_MODE_DEEP = 2'b11
   } cgb_mode_t;

endpackage : cgb_pkg

// [design/cgb_gate_bank.sv]
/*
 * Unit clock gate bank: run and sleep gate registers, gate selection by
 * power mode, per-unit clock enables, bus fault answer for unclocked
 * units, sticky fault status with mask and interrupt.
 * Assumes one AHB-Lite master, word accesses only, and that the
 * deep-sleep gate register lives elsewhere and is fed in as a vector.
 */
`timescale 1ns/1ps
module cgb_gate_bank
   import cgb_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys,
   input wire logic nrst,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // Power mode and external deep-sleep gates
   input wire logic [1:0] cpuMode,
   input wire logic [31:0] deepSleepGates,
   // Gated units: 0 async_serial_zero_gate, 1 sync_serial_zero_gate, 2..4 timers, 5..6 comparators
   output logic [CGB_UNITS-1:0] unitClkEn,
   input wire logic [CGB_UNITS-1:0] unitAccess,
   output logic [CGB_UNITS-1:0] unitFault,
   // Interrupt
   output logic irq
);

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   logic [31:0] runGates;
   logic [31:0] sleepGates;
   logic [31:0] faultStatus;
   logic [31:0] faultMask;
   logic autoSel;
   logic dpWrite;
   logic [ADDR_W-1:0] dpAddr;

   // ---------------------------------------------------------------
   // Bus decode
   // ---------------------------------------------------------------
   // Zero wait states: writes commit in the data phase and the read
   // mux looks at next values, so a read right behind a write is fresh.
   wire addrTaken = hsel & htrans[CGB_HTRANS_ACTIVE_BIT] & hready;
   wire rdTaken = addrTaken & ~hwrite;
   wire wrTaken = addrTaken & hwrite;
   wire [ADDR_W-1:0] addrLow = haddr[ADDR_W-1:0];
   wire wrRun = dpWrite & (dpAddr == CGB_RUN_OFS);
   wire wrSleep = dpWrite & (dpAddr == CGB_SLEEP_OFS);
   wire wrCtrl = dpWrite & (dpAddr == CGB_CTRL_OFS);
   wire wrStat = dpWrite & (dpAddr == CGB_STAT_OFS);
   wire wrMask = dpWrite & (dpAddr == CGB_MASK_OFS);

   // ---------------------------------------------------------------
   // Next register values
   // ---------------------------------------------------------------
   wire [31:0] wrGateVal = hwdata & CGB_GATE_MASK;
   wire [31:0] next_run = wrRun ? wrGateVal : runGates;
   wire [31:0] next_sleep = wrSleep ? wrGateVal : sleepGates;
   wire next_autoSel = wrCtrl ? hwdata[CGB_CTRL_ACG_BIT] : autoSel;
   wire [31:0] next_mask = wrMask ? wrGateVal : faultMask;
   wire [31:0] statClr = wrStat ? hwdata : CGB_RDATA_NONE;
   logic [31:0] faultSet;
   // Set beats clear when a fault lands on the clearing write
   wire [31:0] next_status = ((faultStatus & ~statClr) | faultSet)
                             & CGB_GATE_MASK;
   wire next_irq = |(next_status & next_mask);

   // ---------------------------------------------------------------
   // Read mux
   // ---------------------------------------------------------------
   wire [31:0] ctrlRead = {{(31 - CGB_CTRL_ACG_BIT){1'b0}}, next_autoSel};
   wire hitRun = addrLow == CGB_RUN_OFS;
   wire hitSleep = addrLow == CGB_SLEEP_OFS;
   wire hitCtrl = addrLow == CGB_CTRL_OFS;
   wire hitStat = addrLow == CGB_STAT_OFS;
   wire hitMask = addrLow == CGB_MASK_OFS;
   wire [31:0] readVal = hitRun ? next_run :
                         hitSleep ? next_sleep :
                         hitCtrl ? ctrlRead :
                         hitStat ? next_status :
                         hitMask ? next_mask : CGB_RDATA_NONE;
   wire [31:0] next_hrdata = rdTaken ? readVal : CGB_RDATA_NONE;

   // ---------------------------------------------------------------
   // Gate selection
   // ---------------------------------------------------------------
   // Sleep and deep-sleep sets apply only with auto select on; any
   // unknown mode code falls back to the run set.
   wire inSleep = cpuMode == CGB_MODE_SLEEP;
   wire inDeep = cpuMode == CGB_MODE_DEEP;
   wire [31:0] selGates = !autoSel ? runGates :
                          inSleep ? sleepGates :
                          inDeep ? deepSleepGates :
                          runGates;

   logic [CGB_UNITS-1:0] next_clkEn;
   logic [CGB_UNITS-1:0] next_fault;
   logic [CGB_UNITS-1:0] runUnits;
   logic [CGB_UNITS-1:0] sleepUnits;
   logic [CGB_UNITS-1:0] deepUnits;
   logic [31:0] faultAsStat;

   // ---------------------------------------------------------------
   // Per-unit gate and fault
   // ---------------------------------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < CGB_UNITS; gi++) begin : gUnit
         localparam int B = CGB_UNIT_BIT[gi];
         assign next_clkEn[gi] = selGates[B];
         assign next_fault[gi] = unitAccess[gi] & ~unitClkEn[gi];
         assign runUnits[gi] = runGates[B];
         assign sleepUnits[gi] = sleepGates[B];
         assign deepUnits[gi] = deepSleepGates[B];
      end
   endgenerate

   always_comb begin
      faultSet = CGB_RDATA_NONE;
      faultAsStat = CGB_RDATA_NONE;
      for (int i = 0; i < CGB_UNITS; i++) begin
         faultSet[CGB_UNIT_BIT[i]] = next_fault[i];
         faultAsStat[CGB_UNIT_BIT[i]] = unitFault[i];
      end
   end

   // ---------------------------------------------------------------
   // Registers
   // ---------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         dpWrite <= 1'b0;
         dpAddr <= '0;
      end else begin
         dpWrite <= wrTaken;
         dpAddr <= addrLow;
      end
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         runGates <= CGB_GATE_RESET;
         sleepGates <= CGB_GATE_RESET;
         autoSel <= CGB_ACG_RESET;
         faultStatus <= CGB_GATE_RESET;
         faultMask <= CGB_GATE_RESET;
      end else begin
         runGates <= next_run;
         sleepGates <= next_sleep;
         autoSel <= next_autoSel;
         faultStatus <= next_status;
         faultMask <= next_mask;
      end
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         unitClkEn <= '0;
         unitFault <= '0;
         irq <= 1'b0;
      end else begin
         unitClkEn <= next_clkEn;
         unitFault <= next_fault;
         irq <= next_irq;
      end
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         hrdata <= CGB_RDATA_NONE;
         hreadyout <= 1'b1;
         hresp <= CGB_HRESP_OKAY;
      end else begin
         hrdata <= next_hrdata;
         hreadyout <= 1'b1;
         hresp <= CGB_HRESP_OKAY;
      end
   end

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   default clocking cbClk @(posedge clk_sys);
   endclocking
   default disable iff (!nrst);

   // Reset release must leave every gate off
   AST_RESET_ZERO: assert property (
      @(posedge clk_sys) disable iff (1'b0)
      $rose(nrst) |-> (runGates == CGB_GATE_RESET)
         && (sleepGates == CGB_GATE_RESET) && (unitClkEn == '0))
      else $error("gates not zero after reset");

   AST_RUN_APPLIED: assert property (
      (!autoSel || (cpuMode == CGB_MODE_RUN))
      |=> unitClkEn == $past(runUnits))
      else $error("run gates not applied");

   AST_SLEEP_APPLIED: assert property (
      (autoSel && inSleep) |=> unitClkEn == $past(sleepUnits))
      else $error("sleep gates not applied");

   AST_DEEP_APPLIED: assert property (
      (autoSel && inDeep) |=> unitClkEn == $past(deepUnits))
      else $error("deep-sleep gates not applied");

   AST_FAULT_UNCLOCKED: assert property (
      ((unitAccess & ~unitClkEn) != '0)
      |=> (unitFault & $past(unitAccess & ~unitClkEn))
          == $past(unitAccess & ~unitClkEn))
      else $error("unclocked access gave no fault");

   AST_NO_FAULT_CLOCKED: assert property (
      ((unitAccess & unitClkEn) != '0)
      |=> (unitFault & $past(unitAccess & unitClkEn)) == '0)
      else $error("clocked unit faulted");

   AST_RUN_WRITE: assert property (
      wrRun |=> runGates == ($past(hwdata) & CGB_GATE_MASK))
      else $error("run register write mismatch");

   AST_SLEEP_WRITE: assert property (
      wrSleep |=> sleepGates == ($past(hwdata) & CGB_GATE_MASK))
      else $error("sleep register write mismatch");

   AST_READ_RUN: assert property (
      (rdTaken && hitRun) |=> (hrdata == runGates)
         && ((hrdata & ~CGB_GATE_MASK) == '0))
      else $error("run register read mismatch");

   AST_FAULT_STICKY: assert property (
      (faultAsStat & ~faultStatus) == '0)
      else $error("fault did not set status");

   AST_IRQ_LEVEL: assert property (
      irq == |(faultStatus & faultMask))
      else $error("interrupt level mismatch");

   AST_RESET_OUTPUTS: assert property (
      @(posedge clk_sys) disable iff (1'b0)
      (!nrst ##1 !nrst) |-> (unitClkEn == '0) && (unitFault == '0)
         && !irq && hreadyout && (hresp == CGB_HRESP_OKAY))
      else $error("outputs not idle in reset");

   // ---------------------------------------------------------------
   // Assertions: register file
   // ---------------------------------------------------------------
   // Reserved bits must stay zero whatever software writes
   AST_RUN_RESERVED: assert property (
      (runGates & ~CGB_GATE_MASK) == '0)
      else $error("run register reserved bit set");

   AST_SLEEP_RESERVED: assert property (
      (sleepGates & ~CGB_GATE_MASK) == '0)
      else $error("sleep register reserved bit set");

   AST_MASK_RESERVED: assert property (
      (faultMask & ~CGB_GATE_MASK) == '0)
      else $error("mask register reserved bit set");

   AST_STATUS_RESERVED: assert property (
      (faultStatus & ~CGB_GATE_MASK) == '0)
      else $error("status register reserved bit set");

   // A gate or auto select may only move on a write to its own register
   AST_RUN_HOLD: assert property (
      !wrRun |=> runGates == $past(runGates))
      else $error("run register changed without a write");

   AST_SLEEP_HOLD: assert property (
      !wrSleep |=> sleepGates == $past(sleepGates))
      else $error("sleep register changed without a write");

   AST_CTRL_HOLD: assert property (
      !wrCtrl |=> autoSel == $past(autoSel))
      else $error("auto select changed without a write");

   AST_CTRL_WRITE: assert property (
      wrCtrl |=> autoSel == $past(hwdata[CGB_CTRL_ACG_BIT]))
      else $error("auto select write mismatch");

   AST_MASK_WRITE: assert property (
      wrMask |=> faultMask == ($past(hwdata) & CGB_GATE_MASK))
      else $error("fault mask write mismatch");

   // ---------------------------------------------------------------
   // Assertions: bus answers
   // ---------------------------------------------------------------
   AST_BUS_OKAY: assert property (
      hreadyout && (hresp == CGB_HRESP_OKAY))
      else $error("bus not ready or not okay");

   AST_DATA_PHASE: assert property (
      addrTaken |=> (dpWrite == $past(hwrite))
         && (dpAddr == $past(addrLow)))
      else $error("data phase not captured");

   AST_RDATA_IDLE: assert property (
      !rdTaken |=> hrdata == CGB_RDATA_NONE)
      else $error("read data not zero outside a read");

   AST_READ_SLEEP: assert property (
      (rdTaken && hitSleep) |=> (hrdata == sleepGates)
         && ((hrdata & ~CGB_GATE_MASK) == '0))
      else $error("sleep register read mismatch");

   AST_READ_STAT: assert property (
      (rdTaken && hitStat) |=> hrdata == faultStatus)
      else $error("fault status read mismatch");

   AST_READ_MASK: assert property (
      (rdTaken && hitMask) |=> hrdata == faultMask)
      else $error("fault mask read mismatch");

   AST_UNMAPPED_READ: assert property (
      (rdTaken && !(hitRun || hitSleep || hitCtrl || hitStat || hitMask))
      |=> hrdata == CGB_RDATA_NONE)
      else $error("unmapped read not zero");

   // ---------------------------------------------------------------
   // Assertions: gates and faults
   // ---------------------------------------------------------------
   // Mode codes other than sleep and deep fall back to run gates
   AST_AUTO_RUN_MODE: assert property (
      (autoSel && !inSleep && !inDeep) |=> unitClkEn == $past(runUnits))
      else $error("run gates not applied with auto select");

   AST_FAULT_ONLY_ON_ACCESS: assert property (
      (unitAccess == '0) |=> unitFault == '0)
      else $error("fault without an access");

   // Losing a fault to a racing clear would hide it from software
   AST_STATUS_SET_WINS: assert property (
      (faultSet != '0)
      |=> (faultStatus & $past(faultSet)) == $past(faultSet))
      else $error("fault lost against status clear");

   AST_STATUS_W1C: assert property (
      (wrStat && (faultSet == '0))
      |=> (faultStatus & $past(hwdata)) == '0)
      else $error("status bit not cleared by write");

   // ---------------------------------------------------------------
   // Cover points
   // ---------------------------------------------------------------

   COV_SLEEP_GATE: cover property (autoSel && inSleep ##1 unitClkEn != '0);
   COV_DEEP_GATE: cover property (autoSel && inDeep ##1 unitClkEn != '0);
   COV_FAULT_IRQ: cover property (unitFault != '0 ##1 irq);
   COV_SET_AND_CLEAR: cover property (wrStat && (faultSet != '0));
   COV_RUN_IN_SLEEP: cover property (
      !autoSel && inSleep ##1 unitClkEn != '0);

endmodule : cgb_gate_bank

// [tb/cgb_unit_model.sv]
/* Far side model: gated units that raise one-cycle bus accesses.
   Assumes touch is called just after a rising clock edge. */
`timescale 1ns/1ps
module cgb_unit_model
   import cgb_pkg::*;
(
   // Clock
   input wire logic clk_sys,
   // Unit side
   input wire logic [CGB_UNITS-1:0] unitClkEn,
   output logic [CGB_UNITS-1:0] unitAccess
);
   logic [CGB_UNITS-1:0] expFault;
   initial unitAccess = '0;
   initial expFault = '0;
   // Accesses whether or not the unit is clocked, so faults can be seen
   task automatic touch(input logic [CGB_UNITS-1:0] which);
      // A unit stopped at the sampling edge must see its access faulted
      expFault = which & ~unitClkEn;
      unitAccess <= which;
      @(posedge clk_sys);
      #1;
      unitAccess <= '0;
   endtask : touch
endmodule : cgb_unit_model

// [tb/cgb_gate_bank_tb.sv]
/* Bench for the unit clock gate bank: bus tasks and scenario tasks.
   Assumes one AHB-Lite slave with hready looped from hreadyout. */
`timescale 1ns/1ps
module cgb_gate_bank_tb
   import cgb_pkg::*;
   ;
   logic clk_sys, nrst, hsel, hwrite, hreadyout, hresp, irq, smpRdy, smpRsp;
   logic [31:0] haddr, hwdata, hrdata, deepSleepGates, smpRd, rd;
   logic [1:0] htrans, cpuMode;
   logic [CGB_UNITS-1:0] unitClkEn, unitAccess, unitFault;
   int errTotal, nChecks;
   wire [31:0] enWord = 32'(unitClkEn);

   cgb_gate_bank cgb_gate_bank_inst (.clk_sys(clk_sys), .nrst(nrst),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .cpuMode(cpuMode), .deepSleepGates(deepSleepGates),
      .unitClkEn(unitClkEn), .unitAccess(unitAccess),
      .unitFault(unitFault), .irq(irq));
   cgb_unit_model cgb_unit_model_inst (.clk_sys(clk_sys),
      .unitClkEn(unitClkEn), .unitAccess(unitAccess));

   initial begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end
   // Bus answers are taken at the edge that ends the data phase
   always @(posedge clk_sys) begin
      smpRd <= hrdata;
      smpRdy <= hreadyout;
      smpRsp <= hresp;
   end

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   task automatic tick;
      @(posedge clk_sys);
      #1;
   endtask : tick

   task automatic chk(input logic [31:0] seen, exp, input string msg);
      nChecks++;
      if (seen !== exp) begin
         errTotal++;
         $display("MISMATCH t=%0t %s seen %h exp %h", $time, msg, seen, exp);
      end
   endtask : chk

   function automatic logic [31:0] gates(input logic [31:0] r);
      gates = '0;
      for (int i = 0; i < CGB_UNITS; i++) gates[i] = r[CGB_UNIT_BIT[i]];
   endfunction : gates

   task automatic waitRdy;
      int n;
      n = 0;
      do begin
         tick;
         n++;
      end while (smpRdy !== 1'b1 && n < 50);
      if (smpRdy !== 1'b1) chk(0, 1, "bus wait expired");
   endtask : waitRdy

   task automatic bus(input logic wr, input logic [11:0] a,
         input logic [31:0] wd);
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= {20'h0_0000, a};
      hwrite <= wr;
      waitRdy;
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= wd;
      waitRdy;
      rd = smpRd;
      chk(32'(smpRsp), 0, "response");
   endtask : bus

   task automatic settle;
      repeat (2) tick;
   endtask : settle

   task automatic summarize;
      $display("checks %0d mismatches %0d", nChecks, errTotal);
      if (errTotal == 0 && nChecks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : summarize

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic tReset;
      bus(0, CGB_RUN_OFS, 0);
      chk(rd, CGB_GATE_RESET, "run reset");
      bus(0, CGB_SLEEP_OFS, 0);
      chk(rd, CGB_GATE_RESET, "sleep reset");
      chk(32'(unitClkEn), 0, "enables off");
      $display("reset test done");
   endtask : tReset

   task automatic tMap;
      for (int i = 0; i < CGB_UNITS; i++) begin
         bus(1, CGB_RUN_OFS, 32'h1 << CGB_UNIT_BIT[i]);
         settle;
         chk(enWord, 32'h1 << i, "gate");
      end
      bus(1, CGB_RUN_OFS, 32'hFFFF_FFFF);
      bus(0, CGB_RUN_OFS, 0);
      chk(rd, 32'h0307_0011, "run reserved");
      bus(1, CGB_SLEEP_OFS, 32'hFFFF_FFFF);
      bus(0, CGB_SLEEP_OFS, 0);
      chk(rd, 32'h0307_0011, "sleep reserved");
      bus(0, 12'h300, 0);
      chk(rd, 0, "unmapped read");
      $display("map test done");
   endtask : tMap

   task automatic tFault;
      bus(1, CGB_MASK_OFS, 32'h0001_0000);
      bus(1, CGB_RUN_OFS, 0);
      settle;
      cgb_unit_model_inst.touch(7'h04);
      chk(32'(unitFault), 32'h04, "fault pulse");
      chk(32'(unitFault), 32'(cgb_unit_model_inst.expFault), "model");
      chk(32'(irq), 1, "irq raised");
      tick;
      chk(32'(unitFault), 0, "fault one cycle");
      bus(0, CGB_STAT_OFS, 0);
      chk(rd, 32'h0001_0000, "status sticky");
      bus(1, CGB_STAT_OFS, 32'h0001_0000);
      settle;
      chk(32'(irq), 0, "irq cleared");
      // A fault in the cycle of its clearing write must survive
      fork
         bus(1, CGB_STAT_OFS, 32'h0001_0000);
         begin
            tick;
            cgb_unit_model_inst.touch(7'h04);
         end
      join
      bus(0, CGB_STAT_OFS, 0);
      chk(rd, 32'h0001_0000, "set beats clear");
      chk(32'(irq), 1, "irq raised again");
      bus(1, CGB_STAT_OFS, 32'h0001_0000);
      settle;
      chk(32'(irq), 0, "irq cleared again");
      bus(1, CGB_RUN_OFS, 32'h0001_0000);
      settle;
      cgb_unit_model_inst.touch(7'h04);
      chk(32'(unitFault), 0, "clocked no fault");
      chk(32'(unitFault), 32'(cgb_unit_model_inst.expFault), "model");
      $display("fault test done");
   endtask : tFault

   task automatic tMode;
      bus(1, CGB_RUN_OFS, 32'h0000_0001);
      bus(1, CGB_SLEEP_OFS, 32'h0300_0000);
      deepSleepGates <= 32'h0004_0010;
      cpuMode <= CGB_MODE_SLEEP;
      settle;
      chk(32'(unitClkEn), gates(32'h0000_0001), "no auto sleep");
      bus(1, CGB_CTRL_OFS, 32'h0000_0001);
      settle;
      chk(enWord, gates(32'h0300_0000), "sleep");
      cpuMode <= CGB_MODE_DEEP;
      settle;
      chk(32'(unitClkEn), gates(32'h0004_0010), "deep sleep");
      cpuMode <= CGB_MODE_RUN;
      settle;
      chk(32'(unitClkEn), gates(32'h0000_0001), "run mode");
      $display("mode test done");
   endtask : tMode

   initial begin
      repeat (5000) @(posedge clk_sys);
      errTotal++;
      summarize;
   end

   initial begin
      nrst = 1'b0;
      hsel = 1'b0;
      htrans = 2'b00;
      haddr = '0;
      hwrite = 1'b0;
      hwdata = '0;
      cpuMode = CGB_MODE_RUN;
      deepSleepGates = '0;
      errTotal = 0;
      nChecks = 0;
      repeat (3) @(posedge clk_sys);
      nrst <= 1'b1;
      tick;
      tReset;
      tMap;
      tFault;
      tMode;
      summarize;
   end
endmodule : cgb_gate_bank_tb
